//--- logic/adc_cfg_pkg.sv
// Constants and types for the converter setup and output-format logic.
// Overview of operation
// [R1] Command 01xxxxxx writes the setup register.
// [R2] Clock modes 00/01: internal clock, start pin kept.
// [R3] Modes 10/11 internal or serial clock; pin analog.
// [R4] Reference 00: internal, off after scan, wake delay.
// [R5] Reference 10: internal always on, no delay.
// [R6] Reference 01/11 external; 11 uses negative pin.
// [R7] Pair select 00/01: no data byte follows.
// [R8] Pair select 10: next byte to unipolar register.
// [R9] Pair select 11: next byte to bipolar register.
// [R10] Reset command bit set: clear FIFO only.
// [R11] Reset command bit clear: restore power-up defaults.
// [R12] After power-up all blocks stay shut down.
// [R13] Registers reset zero; setup reset gives mode 10.
// [R14] Temperature is high minus low, minus offset.
// [R15] Temperature LSB is one eighth degree.
// [R16] Output word: four zeros, 12 bits MSB first.
// [R17] Serial input sampled on rising serial clock.
// [R18] Serial output changes on falling serial clock.
// [R19] Start from pin in 00/01, command in 10/11.
// [R20] Unipolar straight binary, bipolar two's complement.
// [R21] Unipolar bit 7 pair 0/1, bit 0 14/15.
// [R22] Bipolar bit 7 pair 0/1, bit 0 14/15.
// [R23] Pair set in both registers is unipolar.
// [R24] Host holds select 16 clocks on pair writes.
// [R25] Command with MSB set is conversion write.
// [R26] Command 0001xxxx is reset; bit 3 is control.
package adc_cfg_pkg;
  localparam logic [7:0] SETUP_RESET = 8'h20;
  localparam logic [7:0] PAIR_RESET = 8'h00;
  localparam int CLK_HI_BIT = 5;
  localparam int CLK_LO_BIT = 4;
  localparam int REF_HI_BIT = 3;
  localparam int REF_LO_BIT = 2;
  localparam int PAIR_HI_BIT = 1;
  localparam int PAIR_LO_BIT = 0;
  localparam int RESET_CTRL_BIT = 3;
  localparam logic [1:0] SEL_PREFIX_SETUP = 2'h1;
  localparam logic [3:0] SEL_PREFIX_RESET = 4'h1;
  localparam logic [1:0] CLK_MODE_INT = 2'h0;
  localparam logic [1:0] CLK_MODE_PIN = 2'h1;
  localparam logic [1:0] CLK_MODE_AUTO = 2'h2;
  localparam logic [1:0] CLK_MODE_SER = 2'h3;
  localparam logic [1:0] REF_INT_AUTO = 2'h0;
  localparam logic [1:0] REF_EXT_SE = 2'h1;
  localparam logic [1:0] REF_INT_ON = 2'h2;
  localparam logic [1:0] REF_EXT_DIFF = 2'h3;
  localparam logic [1:0] PAIR_SEL_UNI = 2'h2;
  localparam logic [1:0] PAIR_SEL_BI = 2'h3;
  localparam int BYTE_BITS = 8;
  localparam int WORD_BITS = 16;
  localparam int RESULT_BITS = 12;
  localparam logic [3:0] LEAD_ZEROS = 4'h0;
  localparam logic [11:0] KELVIN_OFFSET = 12'h888;
  localparam int TEMP_FRAC_BITS = 3;
  typedef enum logic [1:0] {CMD_IDLE, CMD_PAIR_UNI, CMD_PAIR_BI} cmd_state_t;
endpackage : adc_cfg_pkg

//--- logic/adc_setup_and_pair_config.sv
// Serial command decode, configuration registers and output word shifter.
`timescale 1ns/100ps
module adc_setup_and_pair_config (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Serial port pins.
  input wire logic chip_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  // Convert-start pin.
  input wire logic convert_start_n_in,
  // Result sources.
  input wire logic result_valid_in,
  input wire logic [11:0] result_in,
  input wire logic [3:0] result_pair_in,
  input wire logic result_is_temp_in,
  input wire logic [11:0] temp_high_bias_in,
  input wire logic [11:0] temp_low_bias_in,
  input wire logic scan_done_in,
  // Configuration and control outputs.
  output logic [7:0] setup_config_out,
  output logic [7:0] unipolar_pair_out,
  output logic [7:0] bipolar_pair_out,
  output logic [7:0] pair_bipolar_out,
  output logic internal_clock_out,
  output logic pin_is_start_out,
  output logic ref_internal_out,
  output logic ref_powered_out,
  output logic ref_wake_needed_out,
  output logic neg_ref_pin_out,
  output logic convert_request_out,
  output logic [7:0] conversion_cmd_out,
  output logic fifo_clear_out,
  output logic blocks_awake_out
);
  logic cs_n;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  logic cnv_fall;
  logic [7:0] setup_config_q;
  logic [7:0] unipolar_pair_config_q;
  logic [7:0] bipolar_pair_config_q;
  logic [7:0] shift_in_q;
  logic [2:0] bit_cnt_q;
  logic byte_done;
  logic [7:0] rx_byte;
  adc_cfg_pkg::cmd_state_t cmd_state_q;
  logic soft_reset;
  logic [15:0] tx_word_q;
  logic [15:0] out_shift_q;
  logic serial_data_q;
  logic convert_request_q;
  logic [7:0] conversion_cmd_q;
  logic fifo_clear_q;
  logic awake_q;
  logic ref_on_q;
  logic [1:0] clk_mode;
  logic [1:0] ref_mode;
  logic [11:0] temp_celsius;
  logic [11:0] word_value;

  edge_sync #(.IDLE_LEVEL(1'b1)) u_cs (
    .clk_in(clk_in), .rst_in(rst_in), .pin_in(chip_select_n_in),
    .level_out(cs_n), .rise_out(), .fall_out()
  );
  edge_sync #(.IDLE_LEVEL(1'b1)) u_sclk (
    .clk_in(clk_in), .rst_in(rst_in), .pin_in(serial_clk_in),
    .level_out(), .rise_out(sclk_rise), .fall_out(sclk_fall)
  );
  edge_sync u_din (
    .clk_in(clk_in), .rst_in(rst_in), .pin_in(serial_data_in),
    .level_out(din_s), .rise_out(), .fall_out()
  );
  edge_sync #(.IDLE_LEVEL(1'b1)) u_cnv (
    .clk_in(clk_in), .rst_in(rst_in), .pin_in(convert_start_n_in),
    .level_out(), .rise_out(), .fall_out(cnv_fall)
  );

  assign clk_mode = setup_config_q[adc_cfg_pkg::CLK_HI_BIT:adc_cfg_pkg::CLK_LO_BIT];
  assign ref_mode = setup_config_q[adc_cfg_pkg::REF_HI_BIT:adc_cfg_pkg::REF_LO_BIT];

  // Input shift register samples data on serial clock rising edges.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_in_q <= 8'h00;
      bit_cnt_q <= 3'h0;
    end else if (cs_n) begin
      bit_cnt_q <= 3'h0;
    end else if (sclk_rise) begin
      shift_in_q <= {shift_in_q[6:0], din_s}; // R17
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  assign byte_done = !cs_n && sclk_rise && (bit_cnt_q == 3'h7);
  assign rx_byte = {shift_in_q[6:0], din_s};
  assign soft_reset = byte_done && (cmd_state_q == adc_cfg_pkg::CMD_IDLE) &&
      (rx_byte[7:4] == adc_cfg_pkg::SEL_PREFIX_RESET) &&
      !rx_byte[adc_cfg_pkg::RESET_CTRL_BIT]; // R26

  // Command decoder and configuration registers.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      setup_config_q <= adc_cfg_pkg::SETUP_RESET; // R13
      unipolar_pair_config_q <= adc_cfg_pkg::PAIR_RESET;
      bipolar_pair_config_q <= adc_cfg_pkg::PAIR_RESET;
      cmd_state_q <= adc_cfg_pkg::CMD_IDLE;
    end else if (soft_reset) begin
      setup_config_q <= adc_cfg_pkg::SETUP_RESET; // R11
      unipolar_pair_config_q <= adc_cfg_pkg::PAIR_RESET;
      bipolar_pair_config_q <= adc_cfg_pkg::PAIR_RESET;
      cmd_state_q <= adc_cfg_pkg::CMD_IDLE;
    end else if (byte_done) begin
      unique case (cmd_state_q)
        adc_cfg_pkg::CMD_IDLE: begin
          if (!rx_byte[7] && rx_byte[6:6] == adc_cfg_pkg::SEL_PREFIX_SETUP[0:0]) begin
            setup_config_q <= rx_byte; // R1
            if (rx_byte[1:0] == adc_cfg_pkg::PAIR_SEL_UNI) begin
              cmd_state_q <= adc_cfg_pkg::CMD_PAIR_UNI; // R8
            end else if (rx_byte[1:0] == adc_cfg_pkg::PAIR_SEL_BI) begin
              cmd_state_q <= adc_cfg_pkg::CMD_PAIR_BI; // R9
            end else begin
              cmd_state_q <= adc_cfg_pkg::CMD_IDLE; // R7
            end
          end
        end
        adc_cfg_pkg::CMD_PAIR_UNI: begin
          unipolar_pair_config_q <= rx_byte; // R8 R21
          cmd_state_q <= adc_cfg_pkg::CMD_IDLE;
        end
        adc_cfg_pkg::CMD_PAIR_BI: begin
          bipolar_pair_config_q <= rx_byte; // R9 R22
          cmd_state_q <= adc_cfg_pkg::CMD_IDLE;
        end
        default: cmd_state_q <= adc_cfg_pkg::CMD_IDLE;
      endcase
    end
  end

  // Conversion requests and FIFO clear pulses.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      convert_request_q <= 1'b0;
      conversion_cmd_q <= 8'h00;
      fifo_clear_q <= 1'b0;
    end else begin
      convert_request_q <= 1'b0;
      fifo_clear_q <= 1'b0;
      if (byte_done && cmd_state_q == adc_cfg_pkg::CMD_IDLE) begin
        if (rx_byte[7]) begin
          conversion_cmd_q <= rx_byte; // R25
          convert_request_q <= clk_mode[1]; // R19
        end else if (rx_byte[7:4] == adc_cfg_pkg::SEL_PREFIX_RESET) begin
          fifo_clear_q <= 1'b1; // R10
          if (!rx_byte[adc_cfg_pkg::RESET_CTRL_BIT]) begin
            conversion_cmd_q <= 8'h00;
          end
        end
      end else if (cnv_fall && !clk_mode[1]) begin
        convert_request_q <= 1'b1; // R19 R2
      end
    end
  end

  // Power state: asleep after reset until a conversion is requested.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      awake_q <= 1'b0; // R12
      ref_on_q <= 1'b0;
    end else if (soft_reset) begin
      awake_q <= 1'b0; // R12
      ref_on_q <= 1'b0;
    end else begin
      if (convert_request_q) begin
        awake_q <= 1'b1;
      end else if (scan_done_in) begin
        awake_q <= 1'b0;
      end
      if (ref_mode[0]) begin
        ref_on_q <= 1'b0; // R6
      end else if (ref_mode == adc_cfg_pkg::REF_INT_ON || convert_request_q) begin
        ref_on_q <= 1'b1; // R5
      end else if (scan_done_in) begin
        ref_on_q <= 1'b0; // R4
      end
    end
  end

  // Temperature: high bias minus low bias minus Kelvin offset, LSB 1/8 degree.
  assign temp_celsius = temp_high_bias_in - temp_low_bias_in - adc_cfg_pkg::KELVIN_OFFSET; // R14 R15

  // Bipolar if marked bipolar and not unipolar; unipolar wins.
  assign pair_bipolar_out = bipolar_pair_config_q & ~unipolar_pair_config_q; // R23

  always_comb begin
    if (result_is_temp_in) begin
      word_value = temp_celsius;
    end else if (pair_bipolar_out[3'h7 - result_pair_in[3:1]]) begin
      word_value = result_in ^ 12'h800; // R20
    end else begin
      word_value = result_in; // R20
    end
  end

  // Output word loader and shifter.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_word_q <= 16'h0000;
      out_shift_q <= 16'h0000;
      serial_data_q <= 1'b0;
    end else begin
      if (result_valid_in) begin
        tx_word_q <= {adc_cfg_pkg::LEAD_ZEROS, word_value}; // R16
      end
      if (cs_n) begin
        out_shift_q <= tx_word_q;
        serial_data_q <= 1'b0;
      end else if (sclk_fall) begin
        serial_data_q <= out_shift_q[15]; // R18 R16
        out_shift_q <= {out_shift_q[14:0], 1'b0};
      end
    end
  end

  assign setup_config_out = setup_config_q;
  assign unipolar_pair_out = unipolar_pair_config_q;
  assign bipolar_pair_out = bipolar_pair_config_q;
  assign internal_clock_out = (clk_mode != adc_cfg_pkg::CLK_MODE_SER); // R2 R3
  assign pin_is_start_out = !clk_mode[1]; // R2 R3
  assign ref_internal_out = !ref_mode[0]; // R4 R5 R6
  assign ref_powered_out = ref_on_q;
  assign ref_wake_needed_out = (ref_mode == adc_cfg_pkg::REF_INT_AUTO) && !ref_on_q; // R4
  assign neg_ref_pin_out = (ref_mode == adc_cfg_pkg::REF_EXT_DIFF); // R6
  assign convert_request_out = convert_request_q;
  assign conversion_cmd_out = conversion_cmd_q;
  assign fifo_clear_out = fifo_clear_q;
  assign blocks_awake_out = awake_q;
  assign serial_data_out = serial_data_q;

  // Checks of command decode, power state and output word.
  setup_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // R1
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_IDLE && rx_byte[7:6] == 2'h1 && !soft_reset
      |=> setup_config_q == $past(rx_byte))
    else $error("setup byte not stored");
  uni_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // R8
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_PAIR_UNI
      |=> unipolar_pair_config_q == $past(rx_byte))
    else $error("unipolar byte not stored");
  bi_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // R9
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_PAIR_BI
      |=> bipolar_pair_config_q == $past(rx_byte))
    else $error("bipolar byte not stored");
  pair_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // R7
      cmd_state_q == adc_cfg_pkg::CMD_IDLE && !soft_reset
      |=> $stable(unipolar_pair_config_q) && $stable(bipolar_pair_config_q))
    else $error("pair register changed without data byte");
  soft_reset_a: assert property (@(posedge clk_in) disable iff (rst_in) // R11
      soft_reset |=> setup_config_q == adc_cfg_pkg::SETUP_RESET && !awake_q && !ref_on_q &&
      unipolar_pair_config_q == adc_cfg_pkg::PAIR_RESET &&
      bipolar_pair_config_q == adc_cfg_pkg::PAIR_RESET)
    else $error("soft reset did not restore defaults");
  boot_state_a: assert property (@(posedge clk_in) disable iff (rst_in) // R13
      $fell(rst_in)
      |-> setup_config_q == adc_cfg_pkg::SETUP_RESET && !awake_q && !ref_on_q &&
      unipolar_pair_config_q == adc_cfg_pkg::PAIR_RESET &&
      bipolar_pair_config_q == adc_cfg_pkg::PAIR_RESET)
    else $error("power-up state wrong");
  fifo_clr_a: assert property (@(posedge clk_in) disable iff (rst_in) // R10
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_IDLE && rx_byte[7:3] == 5'h03
      |=> fifo_clear_q && $stable(setup_config_q))
    else $error("fifo clear command misbehaved");
  reset_cmd_a: assert property (@(posedge clk_in) disable iff (rst_in) // R26
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_IDLE &&
      rx_byte[7:4] == adc_cfg_pkg::SEL_PREFIX_RESET
      |=> fifo_clear_q)
    else $error("reset command not decoded");
  conv_cmd_a: assert property (@(posedge clk_in) disable iff (rst_in) // R25
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_IDLE && rx_byte[7]
      |=> conversion_cmd_q == $past(rx_byte) && $stable(setup_config_q))
    else $error("conversion byte not decoded");
  serial_req_a: assert property (@(posedge clk_in) disable iff (rst_in) // R19
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_IDLE && rx_byte[7] && clk_mode[1]
      |=> convert_request_q)
    else $error("conversion byte did not start a scan");
  pin_ignored_a: assert property (@(posedge clk_in) disable iff (rst_in) // R3
      clk_mode[1] && !(byte_done && cmd_state_q == adc_cfg_pkg::CMD_IDLE && rx_byte[7])
      |=> !convert_request_q)
    else $error("start pin acted in serial start mode");
  dout_edge_a: assert property (@(posedge clk_in) disable iff (rst_in) // R18
      !sclk_fall && !cs_n ##1 !cs_n
      |-> $stable(serial_data_q))
    else $error("output changed off falling edge");
  data_in_a: assert property (@(posedge clk_in) disable iff (rst_in) // R17
      !cs_n && sclk_rise
      |=> shift_in_q[0] == $past(din_s))
    else $error("input bit not taken on rising edge");
  pin_start_a: assert property (@(posedge clk_in) disable iff (rst_in) // R19
      cnv_fall && !clk_mode[1] && !byte_done
      |=> convert_request_q)
    else $error("start pin ignored");
  awake_req_a: assert property (@(posedge clk_in) disable iff (rst_in) // R12
      convert_request_q && !soft_reset
      |=> awake_q)
    else $error("blocks not woken by request");
  uni_wins_a: assert property (@(posedge clk_in) disable iff (rst_in) // R23
      result_valid_in && !result_is_temp_in && unipolar_pair_config_q[3'h7 - result_pair_in[3:1]]
      |=> tx_word_q[11:0] == $past(result_in))
    else $error("unipolar pair not output as straight binary");
  bipolar_word_a: assert property (@(posedge clk_in) disable iff (rst_in) // R20
      result_valid_in && !result_is_temp_in && pair_bipolar_out[3'h7 - result_pair_in[3:1]]
      |=> tx_word_q[11:0] == ($past(result_in) ^ 12'h800))
    else $error("bipolar pair not output as two's complement");
  temp_word_a: assert property (@(posedge clk_in) disable iff (rst_in) // R14
      result_valid_in && result_is_temp_in
      |=> tx_word_q[11:0] ==
      $past(temp_high_bias_in) - $past(temp_low_bias_in) - adc_cfg_pkg::KELVIN_OFFSET)
    else $error("temperature word wrong");
  word_lead_a: assert property (@(posedge clk_in) disable iff (rst_in) // R16
      result_valid_in
      |=> tx_word_q[15:12] == adc_cfg_pkg::LEAD_ZEROS)
    else $error("output word lacks leading zeros");
  ref_on_a: assert property (@(posedge clk_in) disable iff (rst_in) // R5
      ref_mode == adc_cfg_pkg::REF_INT_ON && !soft_reset
      |=> ref_on_q && !ref_wake_needed_out)
    else $error("reference not kept on");
  ref_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // R6
      ref_mode[0]
      |=> !ref_on_q)
    else $error("internal reference on in external mode");
  wake_delay_a: assert property (@(posedge clk_in) disable iff (rst_in) // R4
      scan_done_in && !convert_request_q && ref_mode == adc_cfg_pkg::REF_INT_AUTO
      |=> !ref_on_q && !awake_q)
    else $error("reference not shut down after scan");

  setup_seen_c: cover property (@(posedge clk_in) disable iff (rst_in)
      byte_done && rx_byte[7:6] == 2'h1);
  uni_seen_c: cover property (@(posedge clk_in) disable iff (rst_in)
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_PAIR_UNI);
  bi_seen_c: cover property (@(posedge clk_in) disable iff (rst_in)
      byte_done && cmd_state_q == adc_cfg_pkg::CMD_PAIR_BI);
  reset_seen_c: cover property (@(posedge clk_in) disable iff (rst_in) soft_reset);
  temp_seen_c: cover property (@(posedge clk_in) disable iff (rst_in)
      result_valid_in && result_is_temp_in);
endmodule : adc_setup_and_pair_config

//--- logic/edge_sync.sv
// Two-flop synchroniser with edge detection for one external pin.
`timescale 1ns/100ps
module edge_sync #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Pin and outputs.
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= IDLE_LEVEL;
      sync_q <= IDLE_LEVEL;
      prev_q <= IDLE_LEVEL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
  assign fall_out = ~sync_q & prev_q;
endmodule : edge_sync

//--- verification/adc_host_model.sv
// Host model that drives the serial port in 16-clock frames.
`timescale 1ns/100ps
module adc_host_model (
  // Serial port toward the device.
  output logic chip_select_n_out,
  output logic serial_clk_out,
  output logic serial_data_out,
  input wire logic serial_data_in
);
  initial begin
    chip_select_n_out = 1'b1;
    serial_clk_out = 1'b1;
    serial_data_out = 1'b0;
  end
  // Sends a command byte and a second byte under one select and gathers the returned word.
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    chip_select_n_out = 1'b0;
    #200;
    for (int i = 15; i >= 0; i--) begin
      serial_clk_out = 1'b0;
      serial_data_out = tx[i];
      #80;
      serial_clk_out = 1'b1;
      rx[i] = serial_data_in;
      #80;
    end
    #100;
    chip_select_n_out = 1'b1;
    serial_data_out = ~serial_data_out;
  endtask : frame
endmodule : adc_host_model

//--- verification/adc_setup_and_pair_config_tb.sv
// Self-checking bench for the setup, pair and output-word logic.
`timescale 1ns/100ps
module adc_setup_and_pair_config_tb;
  typedef struct {int sel; logic [15:0] exp;} note_t;
  logic clk_in, rst_in, cs_n, sck, mosi, miso, convert_start_n_n, res_valid, is_temp, scan_done;
  logic [11:0] res, t_hi, t_lo;
  logic [3:0] res_pair;
  logic [7:0] setup, uni, bi, pbip, conv_cmd, s, u, b;
  logic int_clk, pin_start, ref_int, ref_pwr, ref_wake, neg_ref, conv_req, fifo_clr, awake;
  logic [15:0] rx_word;
  logic [6:0] lv;
  assign lv = {int_clk, pin_start, ref_int, ref_pwr, ref_wake, neg_ref, awake};
  logic [31:0] lfsr;
  int bad_count, samples_checked, req_count, clr_count;
  note_t exp_q[$];
  note_t n;
  event look_ev;
  adc_host_model u_adc_host_model (.chip_select_n_out(cs_n), .serial_clk_out(sck),
    .serial_data_out(mosi), .serial_data_in(miso));
  adc_setup_and_pair_config u_adc_setup_and_pair_config (.clk_in(clk_in), .rst_in(rst_in),
    .chip_select_n_in(cs_n), .serial_clk_in(sck), .serial_data_in(mosi),
    .serial_data_out(miso), .convert_start_n_in(convert_start_n_n), .result_valid_in(res_valid),
    .result_in(res), .result_pair_in(res_pair), .result_is_temp_in(is_temp),
    .temp_high_bias_in(t_hi), .temp_low_bias_in(t_lo), .scan_done_in(scan_done),
    .setup_config_out(setup), .unipolar_pair_out(uni), .bipolar_pair_out(bi),
    .pair_bipolar_out(pbip), .internal_clock_out(int_clk), .pin_is_start_out(pin_start),
    .ref_internal_out(ref_int), .ref_powered_out(ref_pwr), .ref_wake_needed_out(ref_wake),
    .neg_ref_pin_out(neg_ref), .convert_request_out(conv_req),
    .conversion_cmd_out(conv_cmd), .fifo_clear_out(fifo_clr), .blocks_awake_out(awake));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [15:0] dec(input logic [7:0] c, input logic aw);
    return {9'h000, c[5:4] != adc_cfg_pkg::CLK_MODE_SER, c[5] == 1'b0,
      c[3:2] == adc_cfg_pkg::REF_INT_AUTO || c[3:2] == adc_cfg_pkg::REF_INT_ON,
      c[3:2] == adc_cfg_pkg::REF_INT_ON || (c[3:2] == adc_cfg_pkg::REF_INT_AUTO && aw),
      c[3:2] == adc_cfg_pkg::REF_INT_AUTO && !aw,
      c[3:2] == adc_cfg_pkg::REF_EXT_DIFF, aw};
  endfunction : dec
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic note(input int sel, input logic [15:0] e);
    exp_q.push_back('{sel, e});
  endtask : note
  task automatic look;
    -> look_ev;
    @(posedge clk_in);
    #1;
  endtask : look
  task automatic send(input logic [15:0] tx);
    u_adc_host_model.frame(tx, rx_word);
    repeat (20) @(posedge clk_in);
    #1;
  endtask : send
  task automatic pulse_start;
    convert_start_n_n = 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
    convert_start_n_n = 1'b1;
    repeat (10) @(posedge clk_in);
    #1;
  endtask : pulse_start
  always @(posedge clk_in) begin
    if (conv_req === 1'b1) req_count++;
    if (fifo_clr === 1'b1) clr_count++;
  end
  initial begin
    forever begin
      @(look_ev);
      while (exp_q.size() > 0) begin
        n = exp_q.pop_front();
        case (n.sel)
          0: check({setup, uni}, n.exp);
          1: check({bi, pbip}, n.exp);
          2: check({9'h000, lv}, n.exp);
          3: check({req_count[3:0], clr_count[3:0], conv_cmd}, n.exp);
          default: check(rx_word, n.exp);
        endcase
      end
    end
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    end_sim();
  end
  initial begin
    rst_in = 1'b1;
    {convert_start_n_n, res_valid, is_temp, scan_done} = 4'h8;
    {res, t_hi, t_lo, res_pair} = 40'h0;
    lfsr = 32'h2DF9;
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    note(0, {adc_cfg_pkg::SETUP_RESET, adc_cfg_pkg::PAIR_RESET});
    note(1, 16'h0000);
    note(2, dec(8'h20, 1'b0));
    look();
    lfsr = lfsr_next(lfsr);
    {u, b} = lfsr[15:0];
    send({8'h62, u});
    send({8'h63, b});
    for (int i = 0; i < 32; i++) begin
      s = {2'h1, i[4:3], i[2:1], 1'b0, i[0]};
      send({s, 8'h00});
      note(0, {s, u});
      note(1, {b, b & ~u});
      note(2, dec(s, 1'b0));
      look();
    end
    send({8'h60, 8'h00});
    send({8'h81, 8'h00});
    pulse_start();
    note(3, {4'h1, 4'h0, 8'h81});
    note(2, dec(8'h60, 1'b1));
    look();
    scan_done = 1'b1;
    @(posedge clk_in);
    #1 scan_done = 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    note(2, dec(8'h60, 1'b0));
    look();
    send({8'h40, 8'h00});
    send({8'h81, 8'h00});
    note(3, {4'h1, 4'h0, 8'h81});
    look();
    pulse_start();
    note(3, {4'h2, 4'h0, 8'h81});
    look();
    send({8'h62, 8'h40});
    send({8'h63, 8'hC0});
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      {res, t_hi} = lfsr[23:0];
      t_lo = lfsr[31:20];
      res_pair = (k == 0) ? 4'h0 : 4'h2;
      is_temp = (k == 2);
      res_valid = 1'b1;
      @(posedge clk_in);
      #1 res_valid = 1'b0;
      repeat (5) @(posedge clk_in);
      #1;
      send(16'h0000);
      if (k == 0) note(4, {4'h0, res ^ 12'h800});
      else if (k == 1) note(4, {4'h0, res});
      else note(4, {4'h0, t_hi - t_lo - adc_cfg_pkg::KELVIN_OFFSET});
      look();
    end
    send({8'h18, 8'h00});
    note(0, {8'h63, 8'h40});
    note(1, {8'hC0, 8'h80});
    note(3, {4'h2, 4'h1, 8'h81});
    look();
    send({8'h10, 8'h00});
    note(0, {8'h20, 8'h00});
    note(1, 16'h0000);
    note(2, dec(8'h20, 1'b0));
    note(3, {4'h2, 4'h2, 8'h00});
    look();
    end_sim();
  end
endmodule : adc_setup_and_pair_config_tb
